// *** pkg/jtag_char_pkg.sv ***
package jtag_char_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [31:0] CHAR_PORT_ADDR = 32'h10001000;
    localparam logic [31:0] LINK_CTRL_ADDR = 32'h10001004;
    localparam logic [31:0] READ_IDLE      = 32'h00000000;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int COUNT_LSB     = 16;
    localparam int RX_VALID_BIT  = 15;
    localparam int HOST_FLAG_BIT = 10;
    localparam int TX_PEND_BIT   = 9;
    localparam int RX_PEND_BIT   = 8;
    localparam int TX_EN_BIT     = 1;
    localparam int RX_EN_BIT     = 0;

    // ------------------------------------------------------------
    // Storage sizes
    // ------------------------------------------------------------
    localparam int               CHAR_W        = 8;
    localparam int               FIFO_AW       = 6;
    localparam int               CNT_W         = 7;
    localparam logic [CNT_W-1:0] FIFO_FULL_CNT = 7'h40;
    localparam logic [CNT_W-1:0] TX_LOW_WATER  = 7'h20;
    localparam int               XFER_AW       = 1;

    // Reset values
    localparam logic [CNT_W-1:0]   CNT_RESET = 7'h00;
    localparam logic [FIFO_AW-1:0] PTR_RESET = 6'h00;

endpackage

// *** core/cdc_char_fifo.sv ***
`timescale 1ns/10ps
module cdc_char_fifo #(
    parameter int W  = jtag_char_pkg::CHAR_W,
    parameter int AW = jtag_char_pkg::XFER_AW
) (
    // Write side
    input  wire logic         wclk,
    input  wire logic         wnrst,
    input  wire logic         w_valid,
    input  wire logic [W-1:0] w_data,
    output logic              w_ready,
    // Read side
    input  wire logic         rclk,
    input  wire logic         rnrst,
    output logic              r_valid,
    output logic [W-1:0]      r_data,
    input  wire logic         r_ready
);
    import jtag_char_pkg::*;

    // ------------------------------------------------------------
    // Gray pointers, full and empty kept in flops
    // ------------------------------------------------------------
    localparam logic [AW:0] FULL_FLIP = (AW+1)'(3) << (AW-1);

    function automatic logic [AW:0] to_gray(input logic [AW:0] b);
        return b ^ (b >> 1);
    endfunction

    logic [W-1:0] mem_q [2**AW];
    logic [AW:0]  wbin_q;
    logic [AW:0]  wgray_q;
    logic [AW:0]  rbin_q;
    logic [AW:0]  rgray_q;
    logic [AW:0]  rgray_w1_q;
    logic [AW:0]  rgray_w2_q;
    logic [AW:0]  wgray_r1_q;
    logic [AW:0]  wgray_r2_q;
    logic         room_q;
    logic         empty_q;

    wire              w_fire  = w_valid & room_q;
    wire              r_fire  = r_ready & ~empty_q;
    wire [AW:0]       wbin_d  = wbin_q + {{AW{1'b0}}, w_fire};
    wire [AW:0]       rbin_d  = rbin_q + {{AW{1'b0}}, r_fire};
    wire [AW:0]       wgray_d = to_gray(wbin_d);
    wire [AW:0]       rgray_d = to_gray(rbin_d);

    assign w_ready = room_q;
    assign r_valid = ~empty_q;
    assign r_data  = mem_q[rbin_q[AW-1:0]];

    always_ff @(posedge wclk) begin
        if (w_fire) begin
            mem_q[wbin_q[AW-1:0]] <= w_data;
        end
    end

    always_ff @(posedge wclk or negedge wnrst) begin
        if (!wnrst) begin
            wbin_q     <= '0;
            wgray_q    <= '0;
            rgray_w1_q <= '0;
            rgray_w2_q <= '0;
            room_q     <= 1'b1;
        end else begin
            wbin_q     <= wbin_d;
            wgray_q    <= wgray_d;
            rgray_w1_q <= rgray_q;
            rgray_w2_q <= rgray_w1_q;
            room_q     <= (wgray_d != (rgray_w2_q ^ FULL_FLIP));
        end
    end

    always_ff @(posedge rclk or negedge rnrst) begin
        if (!rnrst) begin
            rbin_q     <= '0;
            rgray_q    <= '0;
            wgray_r1_q <= '0;
            wgray_r2_q <= '0;
            empty_q    <= 1'b1;
        end else begin
            rbin_q     <= rbin_d;
            rgray_q    <= rgray_d;
            wgray_r1_q <= wgray_q;
            wgray_r2_q <= wgray_r1_q;
            empty_q    <= (rgray_d == wgray_r2_q);
        end
    end

endmodule

// *** core/jtag_character_uart.sv ***
`timescale 1ns/10ps
module jtag_character_uart (
    // System clock and reset
    input  wire logic                          clk,
    input  wire logic                          nrst,
    // Processor register port
    input  wire logic [31:0]                   cpu_addr,
    input  wire logic                          cpu_rd,
    input  wire logic                          cpu_wr,
    input  wire logic [31:0]                   cpu_wdata,
    output logic      [31:0]                   cpu_rdata,
    output logic                               cpu_rvalid,
    // Link side, all on link_clk
    input  wire logic                          link_clk,
    input  wire logic                          link_rx_valid,
    input  wire logic [jtag_char_pkg::CHAR_W-1:0] link_rx_data,
    output logic                               link_rx_ready,
    output logic                               link_tx_valid,
    output logic      [jtag_char_pkg::CHAR_W-1:0] link_tx_data,
    input  wire logic                          link_tx_ready
);
    import jtag_char_pkg::*;

    function automatic logic [CNT_W-1:0] count_step(input logic [CNT_W-1:0] cnt,
                                                    input logic inc,
                                                    input logic dec);
        return cnt + {{(CNT_W-1){1'b0}}, inc} - {{(CNT_W-1){1'b0}}, dec};
    endfunction

    // ------------------------------------------------------------
    // Link domain reset
    // ------------------------------------------------------------
    logic lnrst_s1_q;
    logic lnrst_q;

    // Release is synchronous so the link flops never see a runt
    always_ff @(posedge link_clk or negedge nrst) begin
        if (!nrst) begin
            lnrst_s1_q <= 1'b0;
            lnrst_q    <= 1'b0;
        end else begin
            lnrst_s1_q <= 1'b1;
            lnrst_q    <= lnrst_s1_q;
        end
    end

    // ------------------------------------------------------------
    // Clock crossings
    // ------------------------------------------------------------
    logic              xr_valid;
    logic [CHAR_W-1:0] xr_data;
    logic              xw_valid;
    logic              xw_ready;
    logic [CHAR_W-1:0] xw_data;
    logic              xt_valid;
    logic [CHAR_W-1:0] xt_data;
    logic              xt_ready;

    // Receive drains freely; overflow is handled at the 64-entry store
    cdc_char_fifo #(.W(CHAR_W), .AW(XFER_AW)) rx_cross (
        .wclk    (link_clk),
        .wnrst   (lnrst_q),
        .w_valid (link_rx_valid),
        .w_data  (link_rx_data),
        .w_ready (link_rx_ready),
        .rclk    (clk),
        .rnrst   (nrst),
        .r_valid (xr_valid),
        .r_data  (xr_data),
        .r_ready (1'b1)
    );

    cdc_char_fifo #(.W(CHAR_W), .AW(XFER_AW)) tx_cross (
        .wclk    (clk),
        .wnrst   (nrst),
        .w_valid (xw_valid),
        .w_data  (xw_data),
        .w_ready (xw_ready),
        .rclk    (link_clk),
        .rnrst   (lnrst_q),
        .r_valid (xt_valid),
        .r_data  (xt_data),
        .r_ready (xt_ready)
    );

    // ------------------------------------------------------------
    // Link output stage and host activity
    // ------------------------------------------------------------
    logic tx_out_valid_q;
    logic [CHAR_W-1:0] tx_out_data_q;
    logic touch_tgl_q;
    logic touch_ack_s1_q;
    logic touch_ack_s2_q;
    logic touch_s1_q;
    logic touch_s2_q;
    logic touch_s3_q;

    assign xt_ready      = ~tx_out_valid_q | link_tx_ready;
    assign link_tx_valid = tx_out_valid_q;
    assign link_tx_data  = tx_out_data_q;

    wire link_rx_take = link_rx_valid & link_rx_ready;
    wire link_tx_take = tx_out_valid_q & link_tx_ready;
    wire touch_idle   = (touch_tgl_q == touch_ack_s2_q);  // Bursts of takes cannot cancel out

    always_ff @(posedge link_clk or negedge lnrst_q) begin
        if (!lnrst_q) begin
            tx_out_valid_q <= 1'b0;
            tx_out_data_q  <= '0;
            touch_tgl_q    <= 1'b0;
            touch_ack_s1_q <= 1'b0;
            touch_ack_s2_q <= 1'b0;
        end else begin
            if (xt_ready) begin
                tx_out_valid_q <= xt_valid;
                tx_out_data_q  <= xt_data;
            end
            touch_tgl_q    <= touch_tgl_q ^ ((link_rx_take | link_tx_take) & touch_idle);
            touch_ack_s1_q <= touch_s2_q;
            touch_ack_s2_q <= touch_ack_s1_q;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            touch_s1_q <= 1'b0;
            touch_s2_q <= 1'b0;
            touch_s3_q <= 1'b0;
        end else begin
            touch_s1_q <= touch_tgl_q;
            touch_s2_q <= touch_s1_q;
            touch_s3_q <= touch_s2_q;
        end
    end

    wire touch_evt = touch_s2_q ^ touch_s3_q;

    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    wire char_sel = (cpu_addr == CHAR_PORT_ADDR);
    wire ctl_sel  = (cpu_addr == LINK_CTRL_ADDR);
    wire char_rd  = cpu_rd & char_sel;
    wire char_wr  = cpu_wr & char_sel;
    wire ctl_rd   = cpu_rd & ctl_sel;
    wire ctl_wr   = cpu_wr & ctl_sel;

    // ------------------------------------------------------------
    // Receive store
    // ------------------------------------------------------------
    logic [CHAR_W-1:0]  rx_mem_q [2**FIFO_AW];
    logic [FIFO_AW-1:0] rx_wptr_q;
    logic [FIFO_AW-1:0] rx_rptr_q;
    logic [CNT_W-1:0]   rx_cnt_q;

    wire              rx_valid = (rx_cnt_q != CNT_RESET);
    wire              rx_push  = xr_valid & (rx_cnt_q != FIFO_FULL_CNT);
    wire              rx_pop   = char_rd & rx_valid;
    wire [CNT_W-1:0]  rx_left  = count_step(rx_cnt_q, 1'b0, rx_pop);
    wire [CHAR_W-1:0] rx_head  = rx_mem_q[rx_rptr_q];

    always_ff @(posedge clk) begin
        if (rx_push) begin
            rx_mem_q[rx_wptr_q] <= xr_data;
        end
    end

    // Only pops and link arrivals move this state, never a write
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rx_wptr_q <= PTR_RESET;
            rx_rptr_q <= PTR_RESET;
            rx_cnt_q  <= CNT_RESET;
        end else begin
            rx_wptr_q <= rx_wptr_q + FIFO_AW'(rx_push);
            rx_rptr_q <= rx_rptr_q + FIFO_AW'(rx_pop);
            rx_cnt_q  <= count_step(rx_cnt_q, rx_push, rx_pop);
        end
    end

    // ------------------------------------------------------------
    // Transmit store
    // ------------------------------------------------------------
    logic [CHAR_W-1:0]  tx_mem_q [2**FIFO_AW];
    logic [FIFO_AW-1:0] tx_wptr_q;
    logic [FIFO_AW-1:0] tx_rptr_q;
    logic [CNT_W-1:0]   tx_cnt_q;

    wire             tx_push       = char_wr & (tx_cnt_q != FIFO_FULL_CNT);
    wire             tx_pop        = xw_valid & xw_ready;
    wire [CNT_W-1:0] tx_free_space = FIFO_FULL_CNT - tx_cnt_q;

    assign xw_valid = (tx_cnt_q != CNT_RESET);
    assign xw_data  = tx_mem_q[tx_rptr_q];

    always_ff @(posedge clk) begin
        if (tx_push) begin
            tx_mem_q[tx_wptr_q] <= cpu_wdata[CHAR_W-1:0];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tx_wptr_q <= PTR_RESET;
            tx_rptr_q <= PTR_RESET;
            tx_cnt_q  <= CNT_RESET;
        end else begin
            tx_wptr_q <= tx_wptr_q + FIFO_AW'(tx_push);
            tx_rptr_q <= tx_rptr_q + FIFO_AW'(tx_pop);
            tx_cnt_q  <= count_step(tx_cnt_q, tx_push, tx_pop);
        end
    end

    // ------------------------------------------------------------
    // Control bits
    // ------------------------------------------------------------
    logic rx_irq_enable_q;
    logic tx_irq_enable_q;
    logic host_touched_flag_q;

    // Pending bits are levels; no interrupt line leaves this block
    wire rx_irq_pending = rx_irq_enable_q & rx_valid;
    wire tx_irq_pending = tx_irq_enable_q & (tx_free_space >= TX_LOW_WATER);

    // Host activity wins over a same-cycle clear
    wire host_touched_flag_d = touch_evt ? 1'b1 :
                               (ctl_wr & cpu_wdata[HOST_FLAG_BIT]) ? 1'b0 :
                               host_touched_flag_q;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rx_irq_enable_q     <= 1'b0;
            tx_irq_enable_q     <= 1'b0;
            host_touched_flag_q <= 1'b0;
        end else begin
            host_touched_flag_q <= host_touched_flag_d;
            if (ctl_wr) begin
                rx_irq_enable_q <= cpu_wdata[RX_EN_BIT];
                tx_irq_enable_q <= cpu_wdata[TX_EN_BIT];
            end
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    wire [31:0] char_word = (32'(rx_left) << COUNT_LSB)
                          | (32'(rx_valid) << RX_VALID_BIT)
                          | 32'(rx_head);
    wire [31:0] ctl_word  = (32'(tx_free_space) << COUNT_LSB)
                          | (32'(host_touched_flag_q) << HOST_FLAG_BIT)
                          | (32'(tx_irq_pending) << TX_PEND_BIT)
                          | (32'(rx_irq_pending) << RX_PEND_BIT)
                          | (32'(tx_irq_enable_q) << TX_EN_BIT)
                          | (32'(rx_irq_enable_q) << RX_EN_BIT);
    wire [31:0] rdata_d   = char_rd ? char_word :
                            ctl_rd  ? ctl_word  : READ_IDLE;

    logic [31:0] rdata_q;
    logic        rvalid_q;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata_q  <= READ_IDLE;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q  <= rdata_d;
            rvalid_q <= cpu_rd;
        end
    end

    assign cpu_rdata  = rdata_q;
    assign cpu_rvalid = rvalid_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_unmapped_read;
        @(posedge clk) disable iff (!nrst)
        (cpu_rd && !char_sel && !ctl_sel) |=> (cpu_rvalid && cpu_rdata == 32'h0);
    endproperty
    a_unmapped_read: assert property (p_unmapped_read)
        else $error("unmapped read did not return zero");

    property p_rx_bound;
        @(posedge clk) disable iff (!nrst)
        rx_cnt_q <= 7'h40;
    endproperty
    a_rx_bound: assert property (p_rx_bound)
        else $error("receive count above 64");

    property p_rx_full_drop;
        @(posedge clk) disable iff (!nrst)
        (rx_cnt_q == 7'h40 && xr_valid && !char_rd) |=> (rx_cnt_q == 7'h40 && $stable(rx_wptr_q));
    endproperty
    a_rx_full_drop: assert property (p_rx_full_drop)
        else $error("full receive store accepted a character");

    property p_pop_count;
        @(posedge clk) disable iff (!nrst)
        (char_rd && rx_cnt_q != 7'h00)
            |=> (cpu_rdata[31:16] == 16'($past(rx_cnt_q)) - 16'h1 && cpu_rdata[15]
                 && cpu_rdata[7:0] == $past(rx_head));
    endproperty
    a_pop_count: assert property (p_pop_count)
        else $error("character read returned wrong count or data");

    property p_empty_read;
        @(posedge clk) disable iff (!nrst)
        (char_rd && rx_cnt_q == 7'h00) |=> (!cpu_rdata[15] && cpu_rdata[31:16] == 16'h0);
    endproperty
    a_empty_read: assert property (p_empty_read)
        else $error("empty read showed valid data");

    property p_write_keeps_rx;
        @(posedge clk) disable iff (!nrst)
        (char_wr && !cpu_rd && !xr_valid) |=> $stable(rx_cnt_q) && $stable(rx_rptr_q);
    endproperty
    a_write_keeps_rx: assert property (p_write_keeps_rx)
        else $error("write disturbed the receive store");

    property p_tx_full_drop;
        @(posedge clk) disable iff (!nrst)
        (char_wr && tx_cnt_q == 7'h40) |=> (tx_cnt_q <= 7'h40 && $stable(tx_wptr_q));
    endproperty
    a_tx_full_drop: assert property (p_tx_full_drop)
        else $error("full transmit store accepted a write");

    property p_space_read;
        @(posedge clk) disable iff (!nrst)
        ctl_rd |=> cpu_rdata[31:16] == 16'h40 - 16'($past(tx_cnt_q));
    endproperty
    a_space_read: assert property (p_space_read)
        else $error("control read returned wrong free space");

    property p_flag_clear;
        @(posedge clk) disable iff (!nrst)
        (ctl_wr && cpu_wdata[10] && !touch_evt) |=> !host_touched_flag_q;
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("host flag not cleared by writing one");

    property p_flag_set;
        @(posedge clk) disable iff (!nrst)
        touch_evt |=> host_touched_flag_q;
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("host activity did not set the flag");

endmodule

// *** tb/host_link_model.sv ***
`timescale 1ns/10ps
module host_link_model (
    // Link clock and reset
    input  wire logic                             link_clk,
    input  wire logic                             nrst,
    // Host to device
    output logic                                  link_rx_valid,
    output logic      [jtag_char_pkg::CHAR_W-1:0] link_rx_data,
    input  wire logic                             link_rx_ready,
    // Device to host
    input  wire logic                             link_tx_valid,
    input  wire logic [jtag_char_pkg::CHAR_W-1:0] link_tx_data,
    output logic                                  link_tx_ready,
    // Bench control
    input  wire logic                             host_stall
);
    import jtag_char_pkg::*;

    // ------------------------------------------------------------
    // Host queues and pacing
    // ------------------------------------------------------------
    logic [CHAR_W-1:0] send_q[$];
    logic [CHAR_W-1:0] rcv_q[$];
    int                wake;
    logic              pace;
    logic              rx_taken;

    initial begin
        link_rx_valid = 1'b0;
        link_rx_data  = 8'h00;
        link_tx_ready = 1'b0;
        wake          = 0;
        pace          = 1'b0;
    end

    // Ready only every other cycle, so the device sees a slow host too
    always @(posedge link_clk) begin
        if (link_tx_valid && link_tx_ready)
            rcv_q.push_back(link_tx_data);
        rx_taken = link_rx_valid && link_rx_ready;
        #1;
        if (!nrst) begin
            wake          = 0;
            link_rx_valid = 1'b0;
            link_tx_ready = 1'b0;
        end else begin
            if (wake < 3)
                wake++;
            if (rx_taken)
                void'(send_q.pop_front());
            if (send_q.size() > 0 && wake >= 3) begin
                link_rx_valid = 1'b1;
                link_rx_data  = send_q[0];
            end else begin
                // Idle data keeps moving so a stale byte never looks valid
                link_rx_valid = 1'b0;
                link_rx_data  = ~link_rx_data;
            end
            pace          = ~pace;
            link_tx_ready = !host_stall && pace;
        end
    end
endmodule

// *** tb/jtag_character_uart_test.sv ***
`timescale 1ns/10ps
module jtag_character_uart_test;
    import jtag_char_pkg::*;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic              clk;
    logic              nrst;
    logic              link_clk;
    logic [31:0]       cpu_addr;
    logic              cpu_rd;
    logic              cpu_wr;
    logic [31:0]       cpu_wdata;
    logic [31:0]       cpu_rdata;
    logic              cpu_rvalid;
    logic              link_rx_valid;
    logic [CHAR_W-1:0] link_rx_data;
    logic              link_rx_ready;
    logic              link_tx_valid;
    logic [CHAR_W-1:0] link_tx_data;
    logic              link_tx_ready;
    logic              host_stall;
    int                bad_count;
    int                comparisons;
    int                cycles;

    jtag_character_uart i_jtag_character_uart (
        .clk(clk), .nrst(nrst), .cpu_addr(cpu_addr), .cpu_rd(cpu_rd), .cpu_wr(cpu_wr),
        .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .cpu_rvalid(cpu_rvalid),
        .link_clk(link_clk), .link_rx_valid(link_rx_valid), .link_rx_data(link_rx_data),
        .link_rx_ready(link_rx_ready), .link_tx_valid(link_tx_valid),
        .link_tx_data(link_tx_data), .link_tx_ready(link_tx_ready));

    host_link_model i_host_link_model (
        .link_clk(link_clk), .nrst(nrst), .link_rx_valid(link_rx_valid),
        .link_rx_data(link_rx_data), .link_rx_ready(link_rx_ready),
        .link_tx_valid(link_tx_valid), .link_tx_data(link_tx_data),
        .link_tx_ready(link_tx_ready), .host_stall(host_stall));

    // ------------------------------------------------------------
    // Clocks and watchdog
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial begin
        link_clk = 1'b0;
        #3.7;
        forever #6 link_clk = ~link_clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            bad_count++;
            $display("CHECK FAILED watchdog expected finish seen hang");
            conclude();
        end
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    function automatic logic [31:0] exp_char(input int c, input logic [7:0] ch);
        return {c[15:0], 1'b1, 7'h00, ch};
    endfunction

    function automatic logic [31:0] exp_ctl(input int fr, input logic ac, input logic wi,
                                            input logic ri, input logic we, input logic re);
        return {fr[15:0], 5'h00, ac, wi, ri, 6'h00, we, re};
    endfunction

    // One strobe cycle; answer looked at in the cycle after
    task automatic reg_rd(input logic [31:0] a, output logic [31:0] d);
        @(posedge clk);
        #1;
        cpu_rd   = 1'b1;
        cpu_addr = a;
        @(posedge clk);
        #1;
        cpu_rd = 1'b0;
        chk("rvalid", 32'h1, {31'h0, cpu_rvalid});
        d = cpu_rdata;
    endtask

    task automatic reg_wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        #1;
        cpu_wr    = 1'b1;
        cpu_addr  = a;
        cpu_wdata = d;
        @(posedge clk);
        #1;
        cpu_wr    = 1'b0;
        cpu_wdata = ~d;
    endtask

    // Crossing latency is a few clocks; the margin covers the slow host pace
    task automatic wait_link();
        for (int i = 0; i < 4000 && i_host_link_model.send_q.size() > 0; i++)
            @(posedge clk);
        repeat (20) @(posedge clk);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_after_reset();
        logic [31:0] d;
        reg_rd(LINK_CTRL_ADDR, d);
        chk("ctrl reset", exp_ctl(64, 0, 0, 0, 0, 0), d);
        reg_rd(CHAR_PORT_ADDR, d);
        chk("empty char", 32'h0, d & 32'hffffff00);
        reg_rd(32'h10001008, d);
        chk("unmapped", 32'h0, d);
        reg_wr(LINK_CTRL_ADDR, 32'h3);
        reg_rd(LINK_CTRL_ADDR, d);
        chk("enables", exp_ctl(64, 0, 1, 0, 1, 1), d);
        reg_wr(LINK_CTRL_ADDR, 32'h0);
        $display("test after_reset done");
    endtask

    task automatic t_rx_order();
        logic [31:0] d;
        logic [7:0]  b[3];
        b = '{8'ha5, 8'h5a, 8'h3c};
        foreach (b[i]) i_host_link_model.send_q.push_back(b[i]);
        wait_link();
        reg_wr(LINK_CTRL_ADDR, 32'h1);
        reg_rd(LINK_CTRL_ADDR, d);
        chk("host flag", exp_ctl(64, 1, 0, 1, 0, 1), d);
        reg_wr(CHAR_PORT_ADDR, 32'h00000077);
        foreach (b[i]) begin
            reg_rd(CHAR_PORT_ADDR, d);
            chk("rx char", exp_char(2 - i, b[i]), d);
        end
        reg_rd(CHAR_PORT_ADDR, d);
        chk("rx drained", 32'h0, d & 32'hffffff00);
        wait_link();
        chk("tx count", 32'h1, i_host_link_model.rcv_q.size());
        chk("tx byte", 32'h77, {24'h0, i_host_link_model.rcv_q[0]});
        i_host_link_model.rcv_q.delete();
        reg_wr(LINK_CTRL_ADDR, 32'h400);
        reg_rd(LINK_CTRL_ADDR, d);
        chk("flag clear", exp_ctl(64, 0, 0, 0, 0, 0), d);
        $display("test rx_order done");
    endtask

    task automatic t_rx_full();
        logic [31:0] d;
        for (int i = 0; i < 70; i++) i_host_link_model.send_q.push_back(8'(i));
        wait_link();
        for (int i = 0; i < 64; i++) begin
            reg_rd(CHAR_PORT_ADDR, d);
            chk("rx full", exp_char(63 - i, 8'(i)), d);
        end
        reg_rd(CHAR_PORT_ADDR, d);
        chk("rx extra", 32'h0, d & 32'hffffff00);
        $display("test rx_full done");
    endtask

    task automatic t_tx_full();
        logic [31:0] d;
        int          n;
        int          kept;
        host_stall = 1'b1;
        // Stalled host: store, crossing and output stage all fill
        kept = int'(FIFO_FULL_CNT) + 2**XFER_AW + 1;
        reg_wr(LINK_CTRL_ADDR, 32'h2);
        for (int i = 0; i < 70; i++) reg_wr(CHAR_PORT_ADDR, 32'(i));
        repeat (20) @(posedge clk);
        reg_rd(LINK_CTRL_ADDR, d);
        chk("tx full", exp_ctl(0, 1, 0, 0, 1, 0), d);
        host_stall = 1'b0;
        for (int i = 0; i < 4000 && (i_host_link_model.rcv_q.size() < kept || link_tx_valid); i++)
            @(posedge clk);
        repeat (20) @(posedge clk);
        reg_rd(LINK_CTRL_ADDR, d);
        chk("tx drained", exp_ctl(64, 1, 1, 0, 1, 0), d);
        n = i_host_link_model.rcv_q.size();
        chk("tx kept", 32'(kept), 32'(n));
        for (int i = 0; i < n; i++)
            chk("tx order", 32'(i), {24'h0, i_host_link_model.rcv_q[i]});
        reg_wr(LINK_CTRL_ADDR, 32'h0);
        $display("test tx_full done");
    endtask

    task automatic t_mid_reset();
        logic [31:0] d;
        i_host_link_model.rcv_q.delete();
        host_stall = 1'b1;
        i_host_link_model.send_q.push_back(8'h42);
        wait_link();
        reg_wr(LINK_CTRL_ADDR, 32'h3);
        for (int i = 0; i < 5; i++) reg_wr(CHAR_PORT_ADDR, 32'(i));
        repeat (20) @(posedge clk);
        reg_rd(LINK_CTRL_ADDR, d);
        chk("ctrl before reset", exp_ctl(62, 1, 1, 1, 1, 1), d);
        nrst = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        nrst = 1'b1;
        host_stall = 1'b0;
        repeat (4) @(posedge clk);
        reg_rd(LINK_CTRL_ADDR, d);
        chk("ctrl after reset", exp_ctl(64, 0, 0, 0, 0, 0), d);
        reg_rd(CHAR_PORT_ADDR, d);
        chk("rx after reset", 32'h0, d & 32'hffffff00);
        repeat (40) @(posedge clk);
        chk("tx after reset", 32'h0, i_host_link_model.rcv_q.size());
        $display("test mid_reset done");
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        nrst        = 1'b0;
        cpu_addr    = 32'h0;
        cpu_rd      = 1'b0;
        cpu_wr      = 1'b0;
        cpu_wdata   = 32'h0;
        host_stall  = 1'b0;
        bad_count   = 0;
        comparisons = 0;
        cycles      = 0;
        repeat (10) @(posedge clk);
        #1;
        nrst = 1'b1;
        repeat (4) @(posedge clk);
        t_after_reset();
        t_rx_order();
        t_rx_full();
        t_tx_full();
        t_mid_reset();
        conclude();
    end
endmodule
